/* File: inc/rh_defs.svh */
// Constants shared by both ends of the read-head process-data link.
// Assumes a 125 MHz core clock; times are given in their own unit.
`ifndef RH_DEFS_SVH
`define RH_DEFS_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define RH_CLK_MHZ 125
`define RH_PULSE_MS 300
`define RH_LONG_MS 5000
`define RH_COMM_TMO_MS 50
`define RH_CYCLE_US 1000
`define RH_POLL_TMO_CYC 8'hFF
// ------------------------------------------------------------
// Frame layout, byte 0 in the top bits
// ------------------------------------------------------------
`define RH_CMD_BITS 64
`define RH_IMG_BITS 128
`define RH_HEADS 4
`define RH_CMD_B0 63:56
`define RH_CMD_B1 55:48
`define RH_CMD_B2 47:40
`define RH_CMD_B3 39:32
`define RH_FLD_ABSENT 31
`define RH_FLD_CNT 30:28
`define RH_FLD_WAFER 27:16
`define RH_FLD_CHIP 15:0
`define RH_CNT_START 3'h0
`define RH_CNT_MAX 3'h7
// ------------------------------------------------------------
// Information field selectors
// ------------------------------------------------------------
`define RH_SUB_DIAG_MAX 4'h3
`define RH_SUB_DEV_ID 4'h9
`define RH_SUB_SW_VER 4'hA
`define RH_SUB_STATUS 4'hB
`define RH_SUB_PARAM 4'hC
// ------------------------------------------------------------
// Controller register offsets and reset values
// ------------------------------------------------------------
`define RH_REG_CMD_A 5'h00
`define RH_REG_CMD_B 5'h04
`define RH_REG_CTRL 5'h08
`define RH_REG_STAT 5'h0C
`define RH_REG_IMG0 5'h10
`define RH_CTRL_RUN 0
`define RH_CMD_RESET 64'h0000000000000000
`endif

/* File: inc/rh_pkg.sv */
// State types of the device end of the read-head link.
// Assumes rh_defs.svh is on the include path.
package rh_pkg;
  typedef enum logic [1:0] {
    RH_L_GREEN = 2'b00,
    RH_L_PULSE = 2'b01,
    RH_L_GAP = 2'b10,
    RH_L_LONG = 2'b11
  } rh_led_st_t;
  typedef enum logic [1:0] {
    RH_P_DETECT = 2'b00,
    RH_P_REQ = 2'b01,
    RH_P_WAIT = 2'b10
  } rh_poll_st_t;
endpackage : rh_pkg

/* File: inc/rh_link_if.sv */
// Process-data link between fieldbus master and read-head device.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`include "rh_defs.svh"
interface rh_link_if;
  logic cycle_stb;
  logic [`RH_CMD_BITS-1:0] cmd_data;
  logic img_valid;
  logic [`RH_IMG_BITS-1:0] img_data;
  modport dev (input cycle_stb, input cmd_data, output img_valid, output img_data);
  modport mst (output cycle_stb, output cmd_data, input img_valid, input img_data);
endinterface : rh_link_if

/* File: core/rh_read_head_dev.sv */
// Read-head interface device: builds the 16-byte process image and drives LEDs.
// Assumes heads answer polls on a simple req/ack port and one core clock.
`timescale 1ns/1ps
`include "rh_defs.svh"
module rh_read_head_dev
  import rh_pkg::*;
#(
  parameter logic [31:0] PULSE_CYC = 32'(`RH_PULSE_MS * `RH_CLK_MHZ * 1000),
  parameter logic [31:0] LONG_CYC = 32'(`RH_LONG_MS * `RH_CLK_MHZ * 1000),
  parameter logic [31:0] COMM_TMO_CYC = 32'(`RH_COMM_TMO_MS * `RH_CLK_MHZ * 1000),
  parameter logic [15:0] DEV_ID = 16'h5A5A,  // Arbitrary value
  parameter logic [15:0] SW_VER = 16'h0101   // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic core_ce,
  rh_link_if.dev link,
  input wire logic [3:0] head_attached,
  output logic [1:0] poll_sel,
  output logic poll_req,
  input wire logic poll_ack,
  input wire logic [27:0] poll_code,
  input wire logic poll_carrier,
  input wire logic [6:0] diag_flags,
  output logic status_green,
  output logic status_red,
  output logic [3:0] head_green,
  output logic [3:0] head_yellow,
  output logic [3:0] head_red
);
  // ------------------------------------------------------------
  // Fault decode: diag_flags = {ni, ek, xk, ea, ra, ia, xa}
  // ------------------------------------------------------------
  logic comm_err;
  logic rom_err;
  logic ram_err;
  assign rom_err = diag_flags[5] | diag_flags[3] | diag_flags[2];
  assign ram_err = diag_flags[4] | diag_flags[1] | diag_flags[0];

  // ------------------------------------------------------------
  // Head polling
  // ------------------------------------------------------------
  rh_poll_st_t pst_q, pst_d;
  logic [3:0] att_q, att_d;
  logic [3:0] bad_q, bad_d;
  logic [1:0] sel_q, sel_d;
  logic [7:0] ptmo_q, ptmo_d;
  logic [27:0] code_q [4];
  logic [27:0] code_d [4];
  logic [2:0] cnt_q [4];
  logic [2:0] cnt_d [4];
  logic [3:0] absent_q, absent_d;

  // Next attached head after the current one, wrapping
  function automatic logic [1:0] rh_next_head(input logic [1:0] cur, input logic [3:0] att);
    logic [1:0] n;
    n = cur;
    for (int i = 1; i <= 4; i++) begin
      if (att[2'(cur + 2'(i))] && n == cur) begin
        n = 2'(cur + 2'(i));
      end
    end
    return n;
  endfunction : rh_next_head

  // Poll sequencing; a silent head is marked defective and skipped past
  always_comb begin
    pst_d = pst_q;
    att_d = att_q;
    bad_d = bad_q;
    sel_d = sel_q;
    ptmo_d = ptmo_q;
    absent_d = absent_q;
    for (int h = 0; h < 4; h++) begin
      code_d[h] = code_q[h];
      cnt_d[h] = cnt_q[h];
    end
    unique case (pst_q)
      RH_P_DETECT: begin
        att_d = head_attached;
        sel_d = rh_next_head(2'h3, head_attached);
        if (head_attached != 4'h0) begin
          pst_d = RH_P_REQ;
        end
      end
      RH_P_REQ: begin
        ptmo_d = 8'h00;
        pst_d = RH_P_WAIT;
      end
      RH_P_WAIT: begin
        ptmo_d = 8'(ptmo_q + 8'h01);
        if (poll_ack) begin
          bad_d[sel_q] = 1'b0;
          absent_d[sel_q] = ~poll_carrier;
          if (poll_carrier) begin
            code_d[sel_q] = poll_code;
            cnt_d[sel_q] = (cnt_q[sel_q] == `RH_CNT_MAX) ? `RH_CNT_START
                                                         : 3'(cnt_q[sel_q] + 3'h1);
          end
          sel_d = rh_next_head(sel_q, att_q);
          pst_d = RH_P_REQ;
        end else if (ptmo_q == `RH_POLL_TMO_CYC) begin
          bad_d[sel_q] = 1'b1;
          absent_d[sel_q] = 1'b1;
          sel_d = rh_next_head(sel_q, att_q);
          pst_d = RH_P_REQ;
        end
      end
      default: pst_d = RH_P_DETECT;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pst_q <= RH_P_DETECT;
      att_q <= 4'h0;
      bad_q <= 4'h0;
      sel_q <= 2'h0;
      ptmo_q <= 8'h00;
      absent_q <= 4'hF;
      for (int h = 0; h < 4; h++) begin
        code_q[h] <= 28'h0000000;
        cnt_q[h] <= `RH_CNT_START;
      end
    end else if (core_ce) begin
      pst_q <= pst_d;
      att_q <= att_d;
      bad_q <= bad_d;
      sel_q <= sel_d;
      ptmo_q <= ptmo_d;
      absent_q <= absent_d;
      for (int h = 0; h < 4; h++) begin
        code_q[h] <= code_d[h];
        cnt_q[h] <= cnt_d[h];
      end
    end
  end

  assign poll_sel = sel_q;
  assign poll_req = (pst_q == RH_P_REQ);

  // ------------------------------------------------------------
  // Process image and command capture
  // ------------------------------------------------------------
  logic [`RH_IMG_BITS-1:0] img_q, img_d;
  logic ival_q, ival_d;
  logic [31:0] wd_q, wd_d;

  function automatic logic [31:0] rh_info(input logic [3:0] sub, input logic [3:0] eo,
                                          input logic [6:0] df, input logic [15:0] par);
    logic [31:0] f;
    f = 32'h00000000;
    if (sub <= `RH_SUB_DIAG_MAX) begin
      f = {4'h0, eo, 8'h00, 3'h0, df[6], df[5], 2'h0, df[4], 4'h0, df[3:0]};
    end else if (sub == `RH_SUB_DEV_ID) begin
      f = {DEV_ID, 16'h0000};
    end else if (sub == `RH_SUB_SW_VER) begin
      f = {SW_VER, 16'h0000};
    end else if (sub == `RH_SUB_STATUS) begin
      f = {4'h0, df[3:0], 3'h0, df[6], df[5], 2'h0, df[4], 16'h0000};
    end else if (sub == `RH_SUB_PARAM) begin
      f = {par, 16'h0000};
    end
    return f;
  endfunction : rh_info

  // Image is frozen at the strobe so all four slots come from one instant
  always_comb begin
    img_d = img_q;
    ival_d = 1'b0;
    wd_d = (wd_q == COMM_TMO_CYC) ? wd_q : 32'(wd_q + 32'h1);
    // only the cyclic strobe moves data
    if (link.cycle_stb) begin
      wd_d = 32'h0;
      ival_d = 1'b1;
      for (int h = 0; h < 4; h++) begin
        if (link.cmd_data[40 + h]) begin
          img_d[127 - 32*h -: 32] = rh_info(link.cmd_data[35:32], ~att_q | bad_q, diag_flags,
                                            link.cmd_data[63:48]);
        end else begin
          img_d[127 - 32*h -: 32] = {absent_q[h], cnt_q[h], code_q[h]};
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      img_q <= 128'h0;
      ival_q <= 1'b0;
      wd_q <= 32'h0;
    end else if (core_ce) begin
      img_q <= img_d;
      ival_q <= ival_d;
      wd_q <= wd_d;
    end
  end

  assign link.img_data = img_q;
  assign link.img_valid = ival_q;
  // Missing strobes or an internal interface fault both count as link trouble
  assign comm_err = (wd_q == COMM_TMO_CYC) | diag_flags[6];

  // ------------------------------------------------------------
  // Status LED sequencer
  // ------------------------------------------------------------
  rh_led_st_t lst_q, lst_d;
  logic [31:0] tmr_q, tmr_d;
  logic [2:0] left_q, left_d;
  logic grn_q, grn_d;
  logic red_q, red_d;
  logic [2:0] want;

  // RAM over ROM over link error
  assign want = ram_err ? 3'h4 : rom_err ? 3'h3 : comm_err ? 3'h1 : 3'h0;

  // Pattern is latched at its start, so a new fault waits for the long red
  always_comb begin
    lst_d = lst_q;
    tmr_d = 32'(tmr_q + 32'h1);
    left_d = left_q;
    unique case (lst_q)
      RH_L_GREEN: begin
        tmr_d = 32'h0;
        if (want != 3'h0) begin
          left_d = want;
          lst_d = RH_L_PULSE;
        end
      end
      RH_L_PULSE: begin
        if (tmr_q == PULSE_CYC - 32'h1) begin
          tmr_d = 32'h0;
          left_d = 3'(left_q - 3'h1);
          lst_d = (left_q == 3'h1) ? RH_L_LONG : RH_L_GAP;
        end
      end
      RH_L_GAP: begin
        if (tmr_q == PULSE_CYC - 32'h1) begin
          tmr_d = 32'h0;
          lst_d = RH_L_PULSE;
        end
      end
      RH_L_LONG: begin
        if (tmr_q == LONG_CYC - 32'h1) begin
          tmr_d = 32'h0;
          left_d = want;
          lst_d = (want != 3'h0) ? RH_L_PULSE : RH_L_GREEN;
        end
      end
    endcase
    grn_d = (lst_d == RH_L_GREEN) || (lst_d == RH_L_PULSE);
    red_d = ~grn_d;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lst_q <= RH_L_GREEN;
      tmr_q <= 32'h0;
      left_q <= 3'h0;
      grn_q <= 1'b1;
      red_q <= 1'b0;
    end else if (core_ce) begin
      lst_q <= lst_d;
      tmr_q <= tmr_d;
      left_q <= left_d;
      grn_q <= grn_d;
      red_q <= red_d;
    end
  end

  assign status_green = grn_q;
  assign status_red = red_q;
  assign head_green = att_q & ~bad_q;
  assign head_yellow = att_q & ~absent_q;
  assign head_red = 4'h0;
endmodule : rh_read_head_dev

/* File: core/rh_bus_master.sv */
// Fieldbus master end: sends command bytes each cycle and keeps the last image.
// Assumes software uses the plain register port with one-cycle read latency.
`timescale 1ns/1ps
`include "rh_defs.svh"
module rh_bus_master
  import rh_pkg::*;
#(
  parameter logic [31:0] CYCLE_CYC = 32'(`RH_CYCLE_US * `RH_CLK_MHZ)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic core_ce,
  rh_link_if.mst link,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // ------------------------------------------------------------
  // Registers and cycle timer
  // ------------------------------------------------------------
  logic [`RH_CMD_BITS-1:0] cmd_q, cmd_d;
  logic run_q, run_d;
  logic [31:0] tmr_q, tmr_d;
  logic stb_q, stb_d;
  logic [`RH_IMG_BITS-1:0] img_q, img_d;
  logic [15:0] icnt_q, icnt_d;
  logic [31:0] rd_q, rd_d;

  // one strobe with eight command bytes per cycle, nothing else
  always_comb begin
    cmd_d = cmd_q;
    run_d = run_q;
    img_d = img_q;
    icnt_d = icnt_q;
    stb_d = 1'b0;
    tmr_d = 32'(tmr_q + 32'h1);
    rd_d = 32'h0;
    if (reg_wr) begin
      unique case (reg_addr)
        `RH_REG_CMD_A: cmd_d[63:32] = reg_wdata;
        `RH_REG_CMD_B: cmd_d[31:0] = reg_wdata;
        `RH_REG_CTRL: run_d = reg_wdata[`RH_CTRL_RUN];
        default: ;
      endcase
    end
    if (!run_q || tmr_q == CYCLE_CYC - 32'h1) begin
      tmr_d = 32'h0;
      stb_d = run_q;
    end
    if (link.img_valid) begin
      img_d = link.img_data;
      icnt_d = 16'(icnt_q + 16'h1);
    end
    // Unmapped offsets read as zero
    if (reg_rd) begin
      unique case (reg_addr)
        `RH_REG_CMD_A: rd_d = cmd_q[63:32];
        `RH_REG_CMD_B: rd_d = cmd_q[31:0];
        `RH_REG_CTRL: rd_d = {31'h0, run_q};
        `RH_REG_STAT: rd_d = {16'h0, icnt_q};
        5'h10: rd_d = img_q[127:96];
        5'h14: rd_d = img_q[95:64];
        5'h18: rd_d = img_q[63:32];
        5'h1C: rd_d = img_q[31:0];
        default: rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= `RH_CMD_RESET;
      run_q <= 1'b0;
      tmr_q <= 32'h0;
      stb_q <= 1'b0;
      img_q <= 128'h0;
      icnt_q <= 16'h0;
      rd_q <= 32'h0;
    end else if (core_ce) begin
      cmd_q <= cmd_d;
      run_q <= run_d;
      tmr_q <= tmr_d;
      stb_q <= stb_d;
      img_q <= img_d;
      icnt_q <= icnt_d;
      rd_q <= rd_d;
    end
  end

  assign link.cycle_stb = stb_q;
  assign link.cmd_data = cmd_q;
  assign reg_rdata = rd_q;
endmodule : rh_bus_master

/* File: verif/rh_link_assertions.sv */
// Checker for the process-data link between master and device.
// Assumes instantiation beside the link interface, one clock domain.
`timescale 1ns/1ps
`include "rh_defs.svh"
module rh_link_assertions
  import rh_pkg::*;
#(
  parameter logic [15:0] DEV_ID = 16'h5A5A,
  parameter logic [15:0] SW_VER = 16'h0101
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cycle_stb,
  input wire logic [`RH_CMD_BITS-1:0] cmd_data,
  input wire logic img_valid,
  input wire logic [`RH_IMG_BITS-1:0] img_data
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------
  // Cycle timing
  // ------
  property p_answer; cycle_stb |=> img_valid; endproperty
  a_answer: assert property (p_answer)
    else $error("image missing one cycle after strobe");
  property p_only; img_valid |-> $past(cycle_stb); endproperty
  a_only: assert property (p_only)
    else $error("image sent without a strobe");
  // Master spacing is ten cycles with the short bench parameter
  property p_gap; cycle_stb |=> !cycle_stb [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("strobes closer than one bus cycle");
  property p_hold; $changed(img_data) |-> img_valid; endproperty
  a_hold: assert property (p_hold)
    else $error("image data moved outside an answer");
  // ------
  // Head 4 substitution
  // ------
  property p_dev_id;
    img_valid && $past(cmd_data[43]) && $past(cmd_data[35:32]) == 4'h9
      |-> img_data[31:0] == {DEV_ID, 16'h0000};
  endproperty
  a_dev_id: assert property (p_dev_id)
    else $error("identification field wrong");
  property p_ver;
    img_valid && $past(cmd_data[43]) && $past(cmd_data[35:32]) == 4'hA
      |-> img_data[31:0] == {SW_VER, 16'h0000};
  endproperty
  a_ver: assert property (p_ver)
    else $error("version field wrong");
  property p_param;
    img_valid && $past(cmd_data[43]) && $past(cmd_data[35:32]) == 4'hC
      |-> img_data[31:0] == {$past(cmd_data[63:48]), 16'h0000};
  endproperty
  a_param: assert property (p_param)
    else $error("parameter field wrong");
  property p_unused;
    img_valid && $past(cmd_data[43])
      && ($past(cmd_data[35:32]) inside {[4'h4:4'h8], [4'hD:4'hF]})
      |-> img_data[31:0] == 32'h0;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused selector field not zero");
endmodule : rh_link_assertions

/* File: verif/tb_read_head_image_and_status_led.sv */
// Bench: master and device joined by the link, software via register port.
// Assumes heads are answered here and share the core clock enable.
`timescale 1ns/1ps
`include "rh_defs.svh"
module tb_read_head_image_and_status_led;
  logic core_clk, rst, core_ce, reg_wr, reg_rd, poll_req, poll_ack, poll_carrier;
  logic status_green, status_red;
  logic [1:0] poll_sel;
  logic [3:0] head_attached, head_green, head_yellow, head_red, mute;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, a, b;
  logic [27:0] poll_code;
  logic [6:0] diag_flags;
  logic [3:0] subs[6] = '{4'h0, 4'h9, 4'hA, 4'hB, 4'hC, 4'h5};
  logic [31:0] sub_exp[6] = '{32'h04000000, 32'h5A5A0000, 32'h01010000,
                              32'h0, 32'h5CA50000, 32'h0};
  logic [6:0] faults[4] = '{7'h01, 7'h08, 7'h40, 7'h09};
  int pulses[4] = '{4, 3, 1, 4};
  int lim[4] = '{9, 3, 0, 0};
  int acks[4] = '{0, 0, 0, 0};
  int n_errors = 0;
  int num_checks = 0;

  rh_link_if link();
  rh_read_head_dev #(.PULSE_CYC(32'h4), .LONG_CYC(32'hC), .COMM_TMO_CYC(32'h28))
  i_rh_read_head_dev (.core_clk(core_clk), .rst(rst), .core_ce(core_ce), .link(link),
    .head_attached(head_attached), .poll_sel(poll_sel), .poll_req(poll_req),
    .poll_ack(poll_ack), .poll_code(poll_code), .poll_carrier(poll_carrier),
    .diag_flags(diag_flags), .status_green(status_green), .status_red(status_red),
    .head_green(head_green), .head_yellow(head_yellow), .head_red(head_red));
  rh_bus_master #(.CYCLE_CYC(32'hA)) i_rh_bus_master (.core_clk(core_clk), .rst(rst),
    .core_ce(core_ce), .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rh_link_assertions i_rh_link_assertions (.core_clk(core_clk), .rst(rst),
    .cycle_stb(link.cycle_stb), .cmd_data(link.cmd_data),
    .img_valid(link.img_valid), .img_data(link.img_data));

  // Clock, 8 ns period
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [27:0] code_of(input int h);
    return {4'(h + 1), 24'h3C5A96};
  endfunction : code_of

  // Heads answer a poll one cycle later unless muted; code lines garble when idle
  // Heads run on the enabled clock, so a frozen poll still sees its answer
  always @(posedge core_clk) begin
    if (core_ce) begin
      poll_ack <= poll_req & ~mute[poll_sel];
      if (poll_req) begin
        poll_code <= code_of(poll_sel);
        poll_carrier <= acks[poll_sel] < lim[poll_sel];
        acks[poll_sel] <= acks[poll_sel] + 1;
      end else begin
        poll_code <= ~poll_code;
        poll_carrier <= ~poll_carrier;
      end
    end
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] ad, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd

  task automatic cf(input int h, input logic [31:0] e);
    logic [31:0] d;
    rd(5'(`RH_REG_IMG0 + 4 * h), d);
    chk("image field", e, d);
  endtask : cf

  // Two fresh images, then room for the master's copy to land
  task automatic wimg;
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(negedge core_clk);
        k++;
      end while (link.img_valid !== 1'b1 && k < 50);
    end
    repeat (3) @(negedge core_clk);
  endtask : wimg

  // Record the LED from the first red cycle up to the next pattern's pulse
  task automatic led(input int n);
    logic [63:0] g, r, e;
    int k, len;
    g = '0;
    r = '0;
    e = '0;
    k = 0;
    len = (n - 1) * 8 + 16;
    do begin
      @(negedge core_clk);
      k++;
    end while (status_green !== 1'b0 && k < 200);
    for (int i = 0; i < len; i++) begin
      g[i] = status_green;
      r[i] = status_red;
      e[i] = (i < len - 16) ? i[2] : (i >= len - 4);
      @(negedge core_clk);
    end
    chk("status green", e, g);
    chk("status red", e ^ ((64'h1 << len) - 64'h1), r);
  endtask : led

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    head_attached = 4'hB;
    diag_flags = '0;
    poll_ack = 1'b0;
    poll_code = '0;
    poll_carrier = 1'b0;
    core_ce = 1'b1;
    mute = 4'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    wr(`RH_REG_CMD_A, 32'h0);
    wr(`RH_REG_CMD_B, 32'hFFFFFFFF);
    wr(`RH_REG_CTRL, 32'h1);
    repeat (15) wimg;
    chk("led state", 64'h2, {status_green, status_red});
    cf(0, {1'b1, 3'h1, code_of(0)});
    cf(1, {1'b1, 3'h3, code_of(1)});
    cf(3, {1'b1, 3'h0, 28'h0});
    chk("head leds", 64'hB00, {head_green, head_yellow, head_red});
    rd(`RH_REG_STAT, a);
    repeat (98) @(posedge core_clk);
    rd(`RH_REG_STAT, b);
    chk("image count", 64'hA, b[15:0] - a[15:0]);
    lim[1] = 1000;
    wimg;
    wimg;
    chk("head yellow", 64'h2, head_yellow);
    // Enable low between answers must stop the cycle timer and the image count
    rd(`RH_REG_STAT, a);
    @(posedge core_clk);
    core_ce <= 1'b0;
    repeat (40) @(posedge core_clk);
    core_ce <= 1'b1;
    rd(`RH_REG_STAT, b);
    chk("frozen image count", 64'h0, b[15:0] - a[15:0]);
    for (int i = 0; i < 6; i++) begin
      wr(`RH_REG_CMD_A, {16'h5CA5, 8'h08, 4'h0, subs[i]});
      wimg;
      cf(3, sub_exp[i]);
    end
    cf(0, {1'b1, 3'h1, code_of(0)});
    // A silent head times out, loses its green and shows as defective
    @(posedge core_clk);
    mute <= 4'h8;
    repeat (600) @(negedge core_clk);
    chk("head green", 64'h3, head_green);
    wr(`RH_REG_CMD_A, 32'h5CA50800);
    wimg;
    cf(3, 32'h0C000000);
    @(posedge core_clk);
    mute <= 4'h0;
    repeat (600) @(negedge core_clk);
    chk("head green", 64'hB, head_green);
    @(posedge core_clk);
    diag_flags <= 7'h7F;
    wr(`RH_REG_CMD_A, 32'h5CA50800);
    wimg;
    cf(3, 32'h0400190F);
    wr(`RH_REG_CMD_A, 32'h5CA5080B);
    wimg;
    cf(3, 32'h0F190000);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      diag_flags <= 7'h0;
      repeat (60) @(negedge core_clk);
      chk("led state", 64'h2, {status_green, status_red});
      @(posedge core_clk);
      diag_flags <= faults[i];
      led(pulses[i]);
    end
    @(posedge core_clk);
    diag_flags <= 7'h0;
    repeat (60) @(negedge core_clk);
    wr(`RH_REG_CTRL, 32'h0);
    led(1);
    wr(`RH_REG_CTRL, 32'h1);
    repeat (60) @(negedge core_clk);
    chk("led state", 64'h2, {status_green, status_red});
    summarize;
  end

  // Watchdog, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    summarize;
  end
endmodule : tb_read_head_image_and_status_led
